// ### logic/rcst_pkg.sv
// Constants, register map and state types of the reset cause and start-up timer block
package rcst_pkg;

  // APB geometry: register index sits in paddr[7:2]
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 6;

  // Register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PCL = 6'h02;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h03;
  localparam logic [IDX_W-1:0] IDX_FSR = 6'h04;
  localparam logic [IDX_W-1:0] IDX_OPTION = 6'h10;
  localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION_REGISTERS_A = 6'h11;
  localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION_REGISTERS_B = 6'h12;
  localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION_REGISTERS_C = 6'h13;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h14;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h15;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h16;

  // Status layout
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_PAGE_LSB = 5;
  localparam int STAT_PAGE_W = 3;
  localparam int STAT_ARITH_W = 3;
  localparam logic [7:0] STATUS_POR_VAL = 8'h18;

  // Reset values of forced registers
  localparam logic [7:0] PCL_RST_VAL = 8'hFF;
  localparam logic [7:0] PIN_DIRECTION_REGISTERS_RST_VAL = 8'hFF;
  localparam logic [5:0] OPTION_RST_VAL = 6'h3F;
  localparam logic [7:0] FSR_POR_VAL = 8'hFF;
  localparam int NUM_PIN_DIRECTION_REGISTERS = 3;

  // Control register bits
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_RC_MODE_BIT = 1;
  localparam int CTRL_W = 2;

  // Interrupt event bits
  localparam int IRQ_POR = 0;
  localparam int IRQ_MASTER_CLEAR_PIN_RST = 1;
  localparam int IRQ_MASTER_CLEAR_PIN_WAKE = 2;
  localparam int IRQ_WDT_RST = 3;
  localparam int IRQ_WDT_WAKE = 4;
  localparam int IRQ_STARTUP_DONE = 5;
  localparam int IRQ_W = 6;

  // Start-up delay in microseconds and default start-up oscillator rate
  localparam int STARTUP_DELAY_US = 18000;
  localparam int DRT_OSC_KHZ_DEF = 1000;
  localparam int DRT_TICKS_DEF = STARTUP_DELAY_US * DRT_OSC_KHZ_DEF / 1000;
  localparam int CNT_W = 20;

  // Clock output divider
  localparam int CLKOUT_DIV = 4;
  localparam int DIV_W = 2;

  typedef enum logic [1:0] {
    ST_WAIT_MASTER_CLEAR_PIN,
    ST_TIMING,
    ST_RUN
  } rcst_phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } rcst_apb_req_t;

  typedef struct packed {
    logic [1:0] master_clear_pin_sync;
    logic [1:0] osc_sync;
    logic osc_prev;
    logic por_seen;
    rcst_phase_t phase;
    logic [CNT_W-1:0] count;
    logic chip_rst;
    logic [7:0] status;
    logic [7:0] program_counter_low;
    logic [7:0] indirect_pointer;
    logic [5:0] option;
    logic [NUM_PIN_DIRECTION_REGISTERS-1:0][7:0] pin_direction_registers;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [DIV_W-1:0] div_cnt;
    logic clkout;
    logic pready;
    logic pslverr;
    logic [APB_DW-1:0] prdata;
  } rcst_state_t;

endpackage : rcst_pkg

// ### logic/rcst_reset_seq.sv
// Reset cause tracking, start-up timer and reset-state registers behind an APB slave
`timescale 1ns/1ns

// Contract
// RULE1: Five reset causes are taken: power-on, master-clear running, master-clear wake, watchdog running, watchdog wake.
// RULE2: A master-clear or watchdog wake-up from sleep does a full reset instead of resuming.
// RULE3: Timeout and powerdown flags sit at status bits 4 and 3, both active low, readable by software.
// RULE4: Power-on sets both flags, master-clear while running keeps both, watchdog while running gives 0 and 1.
// RULE5: Master-clear wake gives timeout 1 and powerdown 0; watchdog wake clears both.
// RULE6: Status loads 0001 1xxx on power-on and 000q quuu on other resets.
// RULE7: Every reset forces the pin direction registers and program counter low to ones and option to six ones.
// RULE8: Working, timer, port and general file registers are not initialised and keep contents across resets.
// RULE9: With a five-bit indirect pointer the unused pointer bits read as ones after any reset.
// RULE10: Power-up sets the reset latch, asserting chip reset, and clears the start-up count.
// RULE11: The start-up timer counts only with master-clear high and releases chip reset after 18 ms.
// RULE12: No internal reset is made when supply voltage falls.
// RULE13: The outside party holds master-clear low until operating conditions are met.
// RULE14: In RC oscillator mode the clock output pin carries the oscillator divided by 4.
// RULE15: The start-up timer runs from its own RC oscillator and the core stays in reset while it runs.
// RULE16: A watchdog timeout restarts the start-up timer as well.
// RULE17: While master-clear is low chip reset is held and the count kept cleared, restarting on release.
module rcst_reset_seq #(
  parameter int DRT_TICKS = rcst_pkg::DRT_TICKS_DEF,
  parameter int PTR_WIDTH = 5
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_MASTER_CLEAR_PIN_N,
  input wire logic I_DRT_OSC,
  input wire logic I_WDT_TIMEOUT,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [rcst_pkg::APB_AW-1:0] I_PADDR,
  input wire logic [rcst_pkg::APB_DW-1:0] I_PWDATA,
  output logic [rcst_pkg::APB_DW-1:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_CHIP_RST,
  output logic O_SLEEP,
  output logic O_CLKOUT,
  output logic O_IRQ,
  output logic [7:0] O_STATUS,
  output logic [7:0] O_PCL,
  output logic [7:0] O_FSR,
  output logic [5:0] O_OPTION,
  output logic [rcst_pkg::NUM_PIN_DIRECTION_REGISTERS*8-1:0] O_PIN_DIRECTION_REGISTERS
);

  localparam logic [rcst_pkg::CNT_W-1:0] TICKS_LAST = rcst_pkg::CNT_W'(DRT_TICKS - 1);
  // Unimplemented pointer bits read as ones
  localparam logic [7:0] FSR_ONES = 8'(~((1 << PTR_WIDTH) - 1));
  localparam logic [rcst_pkg::DIV_W-1:0] DIV_LAST = rcst_pkg::DIV_W'(rcst_pkg::CLKOUT_DIV - 1);
  localparam logic [rcst_pkg::DIV_W-1:0] DIV_HALF = rcst_pkg::DIV_W'(rcst_pkg::CLKOUT_DIV / 2);

  rcst_pkg::rcst_state_t s;
  rcst_pkg::rcst_state_t next_s;
  rcst_pkg::rcst_apb_req_t req;

  assign req.psel = I_PSEL;
  assign req.penable = I_PENABLE;
  assign req.pwrite = I_PWRITE;
  assign req.paddr = I_PADDR;
  assign req.pwdata = I_PWDATA;

  logic master_clear_pin_low;
  logic osc_tick;
  logic sleeping;
  logic master_clear_pin_evt;
  logic wdt_evt;
  logic startup_done;
  logic access;
  logic do_write;
  logic idx_ok;
  logic [rcst_pkg::IDX_W-1:0] idx;
  logic [rcst_pkg::IRQ_W-1:0] events;
  logic [rcst_pkg::APB_DW-1:0] rd_word;

  always_comb begin
    next_s = s;

    // Level and edge views of the synchronised pins
    master_clear_pin_low = !s.master_clear_pin_sync[1];
    osc_tick = s.osc_sync[1] && !s.osc_prev;
    sleeping = s.ctrl[rcst_pkg::CTRL_SLEEP_BIT];
    next_s.master_clear_pin_sync = {s.master_clear_pin_sync[0], I_MASTER_CLEAR_PIN_N};
    next_s.osc_sync = {s.osc_sync[0], I_DRT_OSC};
    next_s.osc_prev = s.osc_sync[1];
    next_s.por_seen = 1'b1;

    // RULE1 master-clear cause detect
    master_clear_pin_evt = master_clear_pin_low && (s.phase != rcst_pkg::ST_WAIT_MASTER_CLEAR_PIN);
    // RULE1 watchdog cause detect
    wdt_evt = I_WDT_TIMEOUT && !master_clear_pin_low && (s.phase == rcst_pkg::ST_RUN);
    startup_done = 1'b0;

    // RULE17 master-clear holds reset
    if (master_clear_pin_low) begin
      next_s.phase = rcst_pkg::ST_WAIT_MASTER_CLEAR_PIN;
      next_s.count = '0;
    end else begin
      case (s.phase)
        // RULE11 count starts on high
        rcst_pkg::ST_WAIT_MASTER_CLEAR_PIN: begin
          next_s.phase = rcst_pkg::ST_TIMING;
          next_s.count = '0;
        end
        // RULE15 own oscillator ticks
        rcst_pkg::ST_TIMING: begin
          if (osc_tick) begin
            if (s.count >= TICKS_LAST) begin
              next_s.phase = rcst_pkg::ST_RUN;
              next_s.count = '0;
              startup_done = 1'b1;
            end else begin
              next_s.count = s.count + 1'b1;
            end
          end
        end
        rcst_pkg::ST_RUN: begin
          // RULE16 watchdog restarts timer
          if (wdt_evt) begin
            next_s.phase = rcst_pkg::ST_TIMING;
            next_s.count = '0;
          end
        end
        default: begin
          next_s.phase = rcst_pkg::ST_WAIT_MASTER_CLEAR_PIN;
          next_s.count = '0;
        end
      endcase
    end

    // RULE15 core held while timing
    next_s.chip_rst = (next_s.phase != rcst_pkg::ST_RUN);

    // APB: one wait state, then pready for one cycle
    idx = req.paddr[rcst_pkg::IDX_LSB +: rcst_pkg::IDX_W];
    access = req.psel && req.penable;
    do_write = access && s.pready && req.pwrite;
    idx_ok = 1'b1;
    rd_word = '0;
    case (idx)
      rcst_pkg::IDX_PCL: rd_word[7:0] = s.program_counter_low;
      // RULE3 flags readable
      rcst_pkg::IDX_STATUS: rd_word[7:0] = s.status;
      rcst_pkg::IDX_FSR: rd_word[7:0] = s.indirect_pointer;
      rcst_pkg::IDX_OPTION: rd_word[5:0] = s.option;
      rcst_pkg::IDX_PIN_DIRECTION_REGISTERS_A: rd_word[7:0] = s.pin_direction_registers[0];
      rcst_pkg::IDX_PIN_DIRECTION_REGISTERS_B: rd_word[7:0] = s.pin_direction_registers[1];
      rcst_pkg::IDX_PIN_DIRECTION_REGISTERS_C: rd_word[7:0] = s.pin_direction_registers[2];
      rcst_pkg::IDX_CTRL: rd_word[rcst_pkg::CTRL_W-1:0] = s.ctrl;
      rcst_pkg::IDX_IRQ_STAT: rd_word[rcst_pkg::IRQ_W-1:0] = s.irq_stat;
      rcst_pkg::IDX_IRQ_MASK: rd_word[rcst_pkg::IRQ_W-1:0] = s.irq_mask;
      default: idx_ok = 1'b0;
    endcase
    if (access && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !idx_ok;
      next_s.prdata = req.pwrite ? '0 : rd_word;
    end else begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end

    // Software writes; cause flags are not writable
    if (do_write && idx_ok) begin
      case (idx)
        rcst_pkg::IDX_PCL: next_s.program_counter_low = req.pwdata[7:0];
        rcst_pkg::IDX_STATUS: begin
          next_s.status[rcst_pkg::STAT_PAGE_LSB +: rcst_pkg::STAT_PAGE_W] =
            req.pwdata[rcst_pkg::STAT_PAGE_LSB +: rcst_pkg::STAT_PAGE_W];
          next_s.status[rcst_pkg::STAT_ARITH_W-1:0] = req.pwdata[rcst_pkg::STAT_ARITH_W-1:0];
        end
        rcst_pkg::IDX_FSR: next_s.indirect_pointer = req.pwdata[7:0] | FSR_ONES;
        rcst_pkg::IDX_OPTION: next_s.option = req.pwdata[5:0];
        rcst_pkg::IDX_PIN_DIRECTION_REGISTERS_A: next_s.pin_direction_registers[0] = req.pwdata[7:0];
        rcst_pkg::IDX_PIN_DIRECTION_REGISTERS_B: next_s.pin_direction_registers[1] = req.pwdata[7:0];
        rcst_pkg::IDX_PIN_DIRECTION_REGISTERS_C: next_s.pin_direction_registers[2] = req.pwdata[7:0];
        rcst_pkg::IDX_CTRL: next_s.ctrl = req.pwdata[rcst_pkg::CTRL_W-1:0];
        rcst_pkg::IDX_IRQ_MASK: next_s.irq_mask = req.pwdata[rcst_pkg::IRQ_W-1:0];
        default: next_s.ctrl = next_s.ctrl;
      endcase
    end

    // Reset state wins over a write landing in the same cycle
    if (next_s.chip_rst) begin
      // RULE6 page bits cleared
      next_s.status[rcst_pkg::STAT_PAGE_LSB +: rcst_pkg::STAT_PAGE_W] = '0;
      // RULE7 forced to ones
      next_s.program_counter_low = rcst_pkg::PCL_RST_VAL;
      next_s.option = rcst_pkg::OPTION_RST_VAL;
      next_s.pin_direction_registers = {rcst_pkg::NUM_PIN_DIRECTION_REGISTERS{rcst_pkg::PIN_DIRECTION_REGISTERS_RST_VAL}};
      // RULE9 unused pointer bits ones
      next_s.indirect_pointer = s.indirect_pointer | FSR_ONES;
      // RULE2 wake is a full reset
      next_s.ctrl[rcst_pkg::CTRL_SLEEP_BIT] = 1'b0;
    end
    // RULE8 arithmetic flags left untouched on warm resets

    // RULE4 master-clear running keeps flags
    // RULE5 master-clear wake gives 1 and 0
    if (master_clear_pin_evt && sleeping) begin
      next_s.status[rcst_pkg::STAT_TO_BIT] = 1'b1;
      next_s.status[rcst_pkg::STAT_PD_BIT] = 1'b0;
    end
    // RULE4 watchdog running gives 0 and 1
    // RULE5 watchdog wake clears both
    if (wdt_evt) begin
      next_s.status[rcst_pkg::STAT_TO_BIT] = 1'b0;
      next_s.status[rcst_pkg::STAT_PD_BIT] = !sleeping;
    end

    // Sticky events; a new event beats a write-one clear
    events = '0;
    events[rcst_pkg::IRQ_POR] = !s.por_seen;
    events[rcst_pkg::IRQ_MASTER_CLEAR_PIN_RST] = master_clear_pin_evt && !sleeping;
    events[rcst_pkg::IRQ_MASTER_CLEAR_PIN_WAKE] = master_clear_pin_evt && sleeping;
    events[rcst_pkg::IRQ_WDT_RST] = wdt_evt && !sleeping;
    events[rcst_pkg::IRQ_WDT_WAKE] = wdt_evt && sleeping;
    events[rcst_pkg::IRQ_STARTUP_DONE] = startup_done;
    if (do_write && (idx == rcst_pkg::IDX_IRQ_STAT)) begin
      next_s.irq_stat = s.irq_stat & ~req.pwdata[rcst_pkg::IRQ_W-1:0];
    end
    next_s.irq_stat = next_s.irq_stat | events;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

    // RULE14 divide by four in RC mode
    if (s.ctrl[rcst_pkg::CTRL_RC_MODE_BIT]) begin
      next_s.div_cnt = (s.div_cnt == DIV_LAST) ? '0 : s.div_cnt + 1'b1;
      next_s.clkout = (next_s.div_cnt >= DIV_HALF);
    end else begin
      next_s.div_cnt = '0;
      next_s.clkout = 1'b0;
    end
  end

  // Only I_RST is a power-on source; a falling supply makes none here
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      // RULE10 latch set, count cleared
      s <= '0;
      s.phase <= rcst_pkg::ST_WAIT_MASTER_CLEAR_PIN;
      s.chip_rst <= 1'b1;
      // RULE6 power-on status value
      s.status <= rcst_pkg::STATUS_POR_VAL;
      s.program_counter_low <= rcst_pkg::PCL_RST_VAL;
      s.indirect_pointer <= rcst_pkg::FSR_POR_VAL;
      s.option <= rcst_pkg::OPTION_RST_VAL;
      s.pin_direction_registers <= {rcst_pkg::NUM_PIN_DIRECTION_REGISTERS{rcst_pkg::PIN_DIRECTION_REGISTERS_RST_VAL}};
    end else begin
      // RULE12 no supply-fall reset path
      s <= next_s;
    end
  end

  assign O_PRDATA = s.prdata;
  assign O_PREADY = s.pready;
  assign O_PSLVERR = s.pslverr;
  assign O_CHIP_RST = s.chip_rst;
  assign O_SLEEP = s.ctrl[rcst_pkg::CTRL_SLEEP_BIT];
  assign O_CLKOUT = s.clkout;
  assign O_IRQ = s.irq;
  assign O_STATUS = s.status;
  assign O_PCL = s.program_counter_low;
  assign O_FSR = s.indirect_pointer;
  assign O_OPTION = s.option;
  assign O_PIN_DIRECTION_REGISTERS = s.pin_direction_registers;

endmodule : rcst_reset_seq

// ### tb/rcst_partner.sv
// Far side model: master-clear driver, watchdog pulse source and start-up oscillator
`timescale 1ns/1ns
module rcst_partner (
  input wire logic i_hold_n,
  input wire logic i_bark,
  output logic o_master_clear_pin_n,
  output logic o_wdt_timeout,
  output logic o_drt_osc
);
  // own oscillator, unrelated to the system clock
  initial begin
    o_drt_osc = 1'b0;
    forever #37 o_drt_osc = ~o_drt_osc;
  end
  // pin held low until the bench says conditions are met
  assign o_master_clear_pin_n = i_hold_n;
  // Bench makes the pulse one cycle long
  assign o_wdt_timeout = i_bark;
endmodule : rcst_partner

// ### tb/rcst_reset_seq_sva.sv
// Port-level properties of the reset sequencer
`timescale 1ns/1ns
module rcst_reset_seq_sva #(
  parameter int DRT_TICKS = 8
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_MASTER_CLEAR_PIN_N,
  input wire logic I_WDT_TIMEOUT,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic O_PREADY,
  input wire logic O_CHIP_RST,
  input wire logic O_SLEEP,
  input wire logic O_CLKOUT,
  input wire logic [7:0] O_STATUS,
  input wire logic [7:0] O_PCL,
  input wire logic [7:0] O_FSR,
  input wire logic [5:0] O_OPTION,
  input wire logic [23:0] O_PIN_DIRECTION_REGISTERS
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  // Saturating run length of master-clear high
  logic [15:0] hi_cnt;
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      hi_cnt <= 16'h0000;
    end else if (!I_MASTER_CLEAR_PIN_N) begin
      hi_cnt <= 16'h0000;
    end else if (hi_cnt != 16'hFFFF) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end
  sequence s_drop;
    (!I_MASTER_CLEAR_PIN_N) [*3];
  endsequence
  sequence s_bark;
    I_WDT_TIMEOUT && !O_CHIP_RST && hi_cnt > 16'h0003;
  endsequence
  sequence s_div;
    O_CLKOUT ##1 (!O_CLKOUT) [*2] ##1 O_CLKOUT;
  endsequence
  property p_por; $fell(I_RST) |-> O_CHIP_RST && O_STATUS[4:3] == 2'b11; endproperty
  property p_hold; s_drop |=> O_CHIP_RST; endproperty
  property p_release; $fell(O_CHIP_RST) |-> hi_cnt >= DRT_TICKS; endproperty
  property p_wdt_run; s_bark ##0 !O_SLEEP |-> ##[1:2] O_CHIP_RST && O_STATUS[4:3] == 2'b01; endproperty
  property p_wdt_wake; s_bark ##0 O_SLEEP |-> ##[1:2] O_CHIP_RST && O_STATUS[4:3] == 2'b00; endproperty
  property p_master_clear_pin_run;
    (!O_CHIP_RST && !O_SLEEP && I_MASTER_CLEAR_PIN_N ##1 s_drop) |=> O_CHIP_RST && O_STATUS[4:3] == $past(O_STATUS[4:3], 4);
  endproperty
  property p_master_clear_pin_wake; (!O_CHIP_RST && O_SLEEP && I_MASTER_CLEAR_PIN_N ##1 s_drop) |=> O_STATUS[4:3] == 2'b10; endproperty
  property p_forced;
    O_CHIP_RST && $past(O_CHIP_RST) |-> O_PCL == 8'hFF && O_OPTION == 6'h3F && O_PIN_DIRECTION_REGISTERS == 24'hFF_FFFF
      && O_STATUS[7:5] == 3'b000 && O_FSR[7:5] == 3'b111;
  endproperty
  property p_clkout; $rose(O_CLKOUT) |=> s_div; endproperty
  property p_ready; $rose(I_PENABLE) && I_PSEL |-> !O_PREADY ##1 O_PREADY ##1 !O_PREADY; endproperty
  a_por: assert property (p_por) else $error("power-on flags wrong");
  a_hold: assert property (p_hold) else $error("chip reset not held");
  a_release: assert property (p_release) else $error("chip reset released early");
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset flags wrong");
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake flags wrong");
  a_master_clear_pin_run: assert property (p_master_clear_pin_run) else $error("master-clear reset flags wrong");
  a_master_clear_pin_wake: assert property (p_master_clear_pin_wake) else $error("master-clear wake flags wrong");
  a_forced: assert property (p_forced) else $error("reset values not forced");
  a_clkout: assert property (p_clkout) else $error("clock output not divided by four");
  a_ready: assert property (p_ready) else $error("bus answer not after one wait state");
endmodule : rcst_reset_seq_sva

bind rcst_reset_seq rcst_reset_seq_sva #(.DRT_TICKS(DRT_TICKS)) i_rcst_reset_seq_sva (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_MASTER_CLEAR_PIN_N(I_MASTER_CLEAR_PIN_N), .I_WDT_TIMEOUT(I_WDT_TIMEOUT),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .O_PREADY(O_PREADY), .O_CHIP_RST(O_CHIP_RST), .O_SLEEP(O_SLEEP),
  .O_CLKOUT(O_CLKOUT), .O_STATUS(O_STATUS), .O_PCL(O_PCL), .O_FSR(O_FSR), .O_OPTION(O_OPTION), .O_PIN_DIRECTION_REGISTERS(O_PIN_DIRECTION_REGISTERS));

// ### tb/rcst_reset_seq_bench.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ns
module rcst_reset_seq_bench;
  localparam int TICKS = 8;
  localparam logic [31:0] ZW = 32'h0000_0000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold_n = 1'b0, bark = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, d;
  logic pready, pslverr, chip_rst, sleep, clkout, irq, master_clear_pin_n, wdt, osc, e;
  logic [7:0] status, program_counter_low, indirect_pointer;
  logic [5:0] option;
  logic [23:0] pin_direction_registers;
  int n_fail = 0;
  int n_checks = 0;
  int n;
  logic [7:0] ra [10] = '{8'h08, 8'h0C, 8'h10, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h7C};
  logic [7:0] rv [10] = '{8'hFF, 8'h18, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h01, 8'h00};
  // Causes: watchdog run, master-clear run, master-clear wake, watchdog wake
  logic cs_slp [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic cs_wdt [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] cs_st [4] = '{8'h0F, 8'h0F, 8'h17, 8'h07};
  int cs_irq [4] = '{3, 1, 2, 4};

  rcst_partner i_rcst_partner (.i_hold_n(hold_n), .i_bark(bark), .o_master_clear_pin_n(master_clear_pin_n), .o_wdt_timeout(wdt),
    .o_drt_osc(osc));
  rcst_reset_seq #(.DRT_TICKS(TICKS)) i_rcst_reset_seq (.I_CLK_SYS(clk), .I_RST(rst), .I_MASTER_CLEAR_PIN_N(master_clear_pin_n),
    .I_DRT_OSC(osc), .I_WDT_TIMEOUT(wdt), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_CHIP_RST(chip_rst), .O_SLEEP(sleep), .O_CLKOUT(clkout), .O_IRQ(irq), .O_STATUS(status),
    .O_PCL(program_counter_low), .O_FSR(indirect_pointer), .O_OPTION(option), .O_PIN_DIRECTION_REGISTERS(pin_direction_registers));

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Trailing edge keeps two transfers from touching psel in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      tally_and_finish();
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wait_run();
    n = 0;
    while (chip_rst !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wait_run

  initial begin
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'(chip_rst), 32'h0000_0001);
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, ra[i], ZW);
      chk(d, 32'(rv[i]));
      chk(32'(e), 32'(i == 9));
    end
    hold_n <= 1'b1;
    wait_run();
    chk(32'(n > 24), 32'h0000_0001);
    apb(1'b0, 8'h54, ZW);
    chk(d, 32'h0000_0021);
    apb(1'b1, 8'h58, 32'h0000_0020);
    @(posedge clk);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, 8'h54, 32'h0000_0020);
    @(posedge clk);
    chk(32'(irq), ZW);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h0C, 32'h0000_00E7);
      apb(1'b1, 8'h08, ZW);
      apb(1'b1, 8'h40, ZW);
      apb(1'b1, 8'h50, 32'(cs_slp[i]));
      @(posedge clk);
      chk(32'(sleep), 32'(cs_slp[i]));
      if (cs_wdt[i]) begin
        bark <= 1'b1;
        @(posedge clk);
        bark <= 1'b0;
        repeat (2) @(posedge clk);
      end else begin
        hold_n <= 1'b0;
        repeat (6) @(posedge clk);
      end
      chk(32'(chip_rst), 32'h0000_0001);
      hold_n <= 1'b1;
      wait_run();
      chk(32'(n > 20), 32'h0000_0001);
      apb(1'b0, 8'h0C, ZW);
      chk(d, 32'(cs_st[i]));
      apb(1'b0, 8'h08, ZW);
      chk(d, 32'h0000_00FF);
      apb(1'b0, 8'h40, ZW);
      chk(d, 32'h0000_003F);
      apb(1'b0, 8'h54, ZW);
      chk(32'(d[cs_irq[i]]), 32'h0000_0001);
      apb(1'b1, 8'h54, 32'h0000_003F);
      chk(32'(sleep), ZW);
    end
    apb(1'b1, 8'h50, 32'h0000_0002);
    repeat (4) @(posedge clk);
    n = 0;
    e = clkout;
    repeat (40) begin
      @(posedge clk);
      if (clkout === 1'b1 && e === 1'b0) n++;
      e = clkout;
    end
    chk(32'(n), 32'h0000_000A);
    tally_and_finish();
  end
endmodule : rcst_reset_seq_bench
